// file: pkg/ucf_params.svh
// Offsets, field positions, codes and reset values of the compare flag unit.
`ifndef UCF_PARAMS_SVH
`define UCF_PARAMS_SVH

`define UCF_OFF_CTRL     8'h00
`define UCF_OFF_OPA      8'h04
`define UCF_OFF_OPB      8'h08
`define UCF_OFF_FLAGS    8'h0c
`define UCF_OFF_STATUS   8'h10
`define UCF_MEM_SEL      2'h1

`define UCF_FC_WORD      8'h14
`define UCF_FC_DWORD     8'h3c
`define UCF_CTRL_REFRESH 8
`define UCF_INPUT_WORD   4'h0

`define UCF_FLAG_GT      0
`define UCF_FLAG_GE      1
`define UCF_FLAG_EQ      2
`define UCF_FLAG_LE      3
`define UCF_FLAG_LT      4
`define UCF_FLAG_NE      5
`define UCF_FLAG_FAULT   6
`define UCF_FLAG_NEG     7
`define UCF_FLAGS_RST    8'h00
`define UCF_ADDR_RST     4'h0
`define UCF_WORD_RST     16'h0000
`define UCF_BUS_RST      32'h0000_0000

`endif

// file: pkg/ucf_pkg.sv
// Types shared by the compare flag unit.
package ucf_pkg;
    typedef logic [15:0] word_t;
    typedef logic [31:0] dword_t;
    typedef logic [7:0]  flags_t;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_RD_LO = 4'h2,
        ST_RD_HI = 4'h4,
        ST_FIN   = 4'h8
    } seq_state_t;
endpackage

// file: pkg/word_store_if.sv
// Port bundle between the compare unit and its operand word store.
`timescale 1ns/1ps
`default_nettype none
interface word_store_if #(parameter int AW = 4, parameter int DW = 16);
    logic [AW-1:0] rd_addr0;
    logic [AW-1:0] rd_addr1;
    logic [DW-1:0] rd_data0;
    logic [DW-1:0] rd_data1;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    modport store (input rd_addr0, rd_addr1, wr_en, wr_addr, wr_data,
                   output rd_data0, rd_data1);
    modport user  (output rd_addr0, rd_addr1, wr_en, wr_addr, wr_data,
                   input rd_data0, rd_data1);
endinterface
`default_nettype wire

// file: design/word_store.sv
// Operand word store with two registered read ports and one write port.
`timescale 1ns/1ps
`default_nettype none
`include "ucf_params.svh"
module word_store #(
    parameter int AW = 4,
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic hce,
    // Access ports
    word_store_if.store port
);
    import ucf_pkg::*;

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rd0_reg;
    logic [DW-1:0] rd0_next;
    logic [DW-1:0] rd1_reg;
    logic [DW-1:0] rd1_next;

    // Read is before write: a read of the word being written sees the old value.
    always_comb begin
        rd0_next = mem[port.rd_addr0];
        rd1_next = mem[port.rd_addr1];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd0_reg <= `UCF_WORD_RST;
            rd1_reg <= `UCF_WORD_RST;
        end else if (hce) begin
            rd0_reg <= rd0_next;
            rd1_reg <= rd1_next;
        end
    end

    always_ff @(posedge hclk) begin
        if (hce && port.wr_en) begin
            mem[port.wr_addr] <= port.wr_data;
        end
    end

    assign port.rd_data0 = rd0_reg;
    assign port.rd_data1 = rd1_reg;
endmodule
`default_nettype wire

// file: design/magnitude_compare.sv
// Unsigned magnitude comparator of configurable width.
`timescale 1ns/1ps
`default_nettype none
module magnitude_compare #(
    parameter int WIDTH = 32
) (
    // Operands
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    // Ordering
    output logic                  gt,
    output logic                  eq,
    output logic                  lt
);
    always_comb begin
        gt = (a > b);
        eq = (a == b);
        lt = (a < b);
    end
endmodule
`default_nettype wire

// file: design/unsigned_compare_flag_unit.sv
// Unsigned word and double-word compare unit with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "ucf_params.svh"
module unsigned_compare_flag_unit #(
    parameter int AW = 4
) (
    // Clock, reset, enable
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hce,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    // Built-in input point word
    input  wire ucf_pkg::word_t ext_in_word,
    // Flags and status
    output logic               greater_flag,
    output logic               greater_equal_flag,
    output logic               equal_flag,
    output logic               less_equal_flag,
    output logic               less_flag,
    output logic               not_equal_flag,
    output logic               fault_flag,
    output logic               negative_flag,
    output logic               busy
);
    import ucf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and wires

    word_store_if #(.AW(AW), .DW(16)) wsp ();

    seq_state_t     st_reg, st_next;
    logic           dword_reg, dword_next;
    logic           refresh_reg, refresh_next;
    logic [AW-1:0]  opa_reg, opa_next;
    logic [AW-1:0]  opb_reg, opb_next;
    word_t          a_lo_reg, a_lo_next;
    word_t          b_lo_reg, b_lo_next;
    flags_t         flags_reg, flags_next;

    logic           dph_reg, dph_next;
    logic           dph_wr_reg, dph_wr_next;
    logic [7:0]     dph_addr_reg, dph_addr_next;
    logic           rd_pend_reg, rd_pend_next;
    logic           rd_issued_reg, rd_issued_next;
    logic [31:0]    hrdata_reg, hrdata_next;

    logic           addr_take;
    logic           wr_now;
    logic           start;
    logic           bus_mem_rd;
    logic           flag_update;
    word_t          a_lo_now, b_lo_now;
    dword_t         cmp_a, cmp_b;
    logic           cmp_gt, cmp_eq, cmp_lt;

    word_store #(.AW(AW), .DW(16)) u_store (
        .hclk    (hclk),
        .hresetn (hresetn),
        .hce     (hce),
        .port    (wsp.store)
    );

    magnitude_compare #(.WIDTH(32)) u_cmp (
        .a  (cmp_a),
        .b  (cmp_b),
        .gt (cmp_gt),
        .eq (cmp_eq),
        .lt (cmp_lt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    assign addr_take = hsel && htrans[1] && hready;
    assign wr_now    = dph_reg && dph_wr_reg;
    assign start     = wr_now && (dph_addr_reg == `UCF_OFF_CTRL) && (st_reg == ST_IDLE)
                       && ((hwdata[7:0] == `UCF_FC_WORD) || (hwdata[7:0] == `UCF_FC_DWORD));
    // The store's first read port is lent to the bus only while no compare runs.
    assign bus_mem_rd = rd_pend_reg && (st_reg == ST_IDLE);

    always_comb begin
        dph_next       = dph_reg;
        dph_wr_next    = dph_wr_reg;
        dph_addr_next  = dph_addr_reg;
        rd_pend_next   = rd_pend_reg;
        rd_issued_next = 1'b0;
        hrdata_next    = hrdata_reg;
        opa_next       = opa_reg;
        opb_next       = opb_reg;
        if (hreadyout) begin
            dph_next      = addr_take;
            dph_wr_next   = hwrite;
            dph_addr_next = haddr[7:0];
            if (addr_take && !hwrite) begin
                if (haddr[7:6] == `UCF_MEM_SEL) begin
                    rd_pend_next = 1'b1;
                end else begin
                    case (haddr[7:0])
                        `UCF_OFF_OPA:    hrdata_next = {{(32-AW){1'b0}}, opa_reg};
                        `UCF_OFF_OPB:    hrdata_next = {{(32-AW){1'b0}}, opb_reg};
                        `UCF_OFF_FLAGS:  hrdata_next = {24'h00_0000, flags_reg};
                        `UCF_OFF_STATUS: hrdata_next = {31'h0000_0000, busy};
                        default:         hrdata_next = `UCF_BUS_RST;
                    endcase
                end
            end
        end
        if (bus_mem_rd) begin
            rd_pend_next   = 1'b0;
            rd_issued_next = 1'b1;
        end
        if (rd_issued_reg) begin
            hrdata_next = {16'h0000, wsp.rd_data0};
        end
        if (wr_now && (st_reg == ST_IDLE)) begin
            if (dph_addr_reg == `UCF_OFF_OPA) opa_next = hwdata[AW-1:0];
            if (dph_addr_reg == `UCF_OFF_OPB) opb_next = hwdata[AW-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_reg       <= 1'b0;
            dph_wr_reg    <= 1'b0;
            dph_addr_reg  <= 8'h00;
            rd_pend_reg   <= 1'b0;
            rd_issued_reg <= 1'b0;
            hrdata_reg    <= `UCF_BUS_RST;
            opa_reg       <= `UCF_ADDR_RST;
            opb_reg       <= `UCF_ADDR_RST;
        end else if (hce) begin
            dph_reg       <= dph_next;
            dph_wr_reg    <= dph_wr_next;
            dph_addr_reg  <= dph_addr_next;
            rd_pend_reg   <= rd_pend_next;
            rd_issued_reg <= rd_issued_next;
            hrdata_reg    <= hrdata_next;
            opa_reg       <= opa_next;
            opb_reg       <= opb_next;
        end
    end

    assign hreadyout = !(rd_pend_reg || rd_issued_reg);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Compare sequencer

    // Live input replaces the stored image only for the built-in input word.
    always_comb begin
        a_lo_now = wsp.rd_data0;
        b_lo_now = wsp.rd_data1;
        if (refresh_reg && (opa_reg == `UCF_INPUT_WORD)) a_lo_now = ext_in_word;
        if (refresh_reg && (opb_reg == `UCF_INPUT_WORD)) b_lo_now = ext_in_word;
    end

    assign flag_update = hce && (((st_reg == ST_RD_HI) && !dword_reg) || (st_reg == ST_FIN));

    always_comb begin
        if (st_reg == ST_FIN) begin
            cmp_a = {wsp.rd_data0, a_lo_reg};
            cmp_b = {wsp.rd_data1, b_lo_reg};
        end else begin
            cmp_a = {16'h0000, a_lo_now};
            cmp_b = {16'h0000, b_lo_now};
        end
    end

    always_comb begin
        wsp.rd_addr0 = bus_mem_rd ? dph_addr_reg[AW+1:2] : opa_reg;
        wsp.rd_addr1 = opb_reg;
        if (st_reg == ST_RD_HI) begin
            wsp.rd_addr0 = opa_reg + 1'b1;
            wsp.rd_addr1 = opb_reg + 1'b1;
        end
        // Refresh also renews the stored image; a bus write in that cycle is lost.
        wsp.wr_en   = wr_now && (dph_addr_reg[7:6] == `UCF_MEM_SEL);
        wsp.wr_addr = dph_addr_reg[AW+1:2];
        wsp.wr_data = hwdata[15:0];
        if ((st_reg == ST_RD_HI) && refresh_reg) begin
            wsp.wr_en   = 1'b1;
            wsp.wr_addr = AW'(`UCF_INPUT_WORD);
            wsp.wr_data = ext_in_word;
        end
    end

    always_comb begin
        st_next      = st_reg;
        dword_next   = dword_reg;
        refresh_next = refresh_reg;
        a_lo_next    = a_lo_reg;
        b_lo_next    = b_lo_reg;
        flags_next   = flags_reg;
        // Software may write the flags to stand in for other flag-affecting steps.
        if (wr_now && (dph_addr_reg == `UCF_OFF_FLAGS)) flags_next = hwdata[7:0];
        case (st_reg)
            ST_IDLE: begin
                if (start) begin
                    dword_next   = (hwdata[7:0] == `UCF_FC_DWORD);
                    refresh_next = (hwdata[7:0] == `UCF_FC_WORD) && hwdata[`UCF_CTRL_REFRESH];
                    st_next      = ST_RD_LO;
                end
            end
            ST_RD_LO: st_next = ST_RD_HI;
            ST_RD_HI: begin
                a_lo_next = a_lo_now;
                b_lo_next = b_lo_now;
                st_next   = dword_reg ? ST_FIN : ST_IDLE;
            end
            ST_FIN:   st_next = ST_IDLE;
            default:  st_next = ST_IDLE;
        endcase
        if (flag_update) begin
            flags_next[`UCF_FLAG_GT] = cmp_gt;
            flags_next[`UCF_FLAG_GE] = cmp_gt || cmp_eq;
            flags_next[`UCF_FLAG_EQ] = cmp_eq;
            flags_next[`UCF_FLAG_LE] = cmp_lt || cmp_eq;
            flags_next[`UCF_FLAG_LT] = cmp_lt;
            flags_next[`UCF_FLAG_NE] = !cmp_eq;
            // Fault and negative bits keep their values.
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg      <= ST_IDLE;
            dword_reg   <= 1'b0;
            refresh_reg <= 1'b0;
            a_lo_reg    <= `UCF_WORD_RST;
            b_lo_reg    <= `UCF_WORD_RST;
            flags_reg   <= `UCF_FLAGS_RST;
        end else if (hce) begin
            st_reg      <= st_next;
            dword_reg   <= dword_next;
            refresh_reg <= refresh_next;
            a_lo_reg    <= a_lo_next;
            b_lo_reg    <= b_lo_next;
            flags_reg   <= flags_next;
        end
    end

    assign busy               = (st_reg != ST_IDLE);
    assign greater_flag       = flags_reg[`UCF_FLAG_GT];
    assign greater_equal_flag = flags_reg[`UCF_FLAG_GE];
    assign equal_flag         = flags_reg[`UCF_FLAG_EQ];
    assign less_equal_flag    = flags_reg[`UCF_FLAG_LE];
    assign less_flag          = flags_reg[`UCF_FLAG_LT];
    assign not_equal_flag     = flags_reg[`UCF_FLAG_NE];
    assign fault_flag         = flags_reg[`UCF_FLAG_FAULT];
    assign negative_flag      = flags_reg[`UCF_FLAG_NEG];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_word_start;
        start && hce && (hwdata[7:0] == `UCF_FC_WORD);
    endsequence
    sequence s_dword_start;
        start && hce && (hwdata[7:0] == `UCF_FC_DWORD);
    endsequence

    AST_WORD_LATENCY: assert property ((s_word_start ##1 hce) |=> flag_update)
        else $error("word compare did not finish two cycles after start");
    AST_DWORD_LATENCY: assert property ((s_dword_start ##1 hce ##1 hce) |=> flag_update)
        else $error("double-word compare did not finish three cycles after start");
    AST_WORD_ORDER: assert property (flag_update && !dword_reg |=>
        (greater_flag == ($past(cmp_a[15:0]) > $past(cmp_b[15:0]))))
        else $error("word compare greater flag wrong");
    AST_DWORD_ORDER: assert property (flag_update && dword_reg |=>
        (less_flag == ($past(cmp_a) < $past(cmp_b))))
        else $error("double-word compare less flag wrong");
    AST_HIGH_WORD_ADDR: assert property ((st_reg == ST_RD_HI) && dword_reg |->
        (wsp.rd_addr0 == AW'(opa_reg + 1'b1)) && (wsp.rd_addr1 == AW'(opb_reg + 1'b1)))
        else $error("high word not read from address plus one");
    AST_EQUAL_PATTERN: assert property (flag_update && cmp_eq |=>
        (flags_reg[5:0] == 6'h0e))
        else $error("equal pattern wrong");
    AST_GREATER_PATTERN: assert property (flag_update && dword_reg && cmp_gt |=>
        (flags_reg[5:0] == 6'h23))
        else $error("double-word greater pattern wrong");
    AST_REFRESH_LIVE: assert property (flag_update && refresh_reg &&
        (opa_reg == `UCF_INPUT_WORD) |-> (cmp_a[15:0] == ext_in_word))
        else $error("refresh compare used stored image");
    AST_KEEP_FAULT_NEG: assert property (flag_update &&
        !(wr_now && (dph_addr_reg == `UCF_OFF_FLAGS)) |=>
        (flags_reg[7:6] == $past(flags_reg[7:6])))
        else $error("compare changed fault or negative flag");
endmodule
`default_nettype wire

// file: dv/ahb_seq_model.sv
// Sequencer model that masters the register bus with single word transfers.
`timescale 1ns/1ps
`default_nettype none
module ahb_seq_model (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Master side of the bus
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Read results
    output logic             rvalid,
    output logic [31:0]      rdata
);
    initial begin
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        rvalid = 1'b0;
        rdata = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write data is inverted in every address phase and every read data phase, so a stale value never looks valid.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge hclk);
        haddr <= {24'h00_0000, addr};
        htrans <= 2'b10;
        hwrite <= wr;
        hwdata <= ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wr ? data : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        if (!wr) begin
            rdata <= hrdata;
            rvalid <= 1'b1;
            @(posedge hclk);
            rvalid <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the unsigned compare flag unit.
`timescale 1ns/1ps
`default_nettype none
`include "ucf_params.svh"
module tb;
    import ucf_pkg::*;
    typedef struct {string name; logic [31:0] val;} note_t;
    logic        hclk;
    logic        hresetn;
    logic        hce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rvalid;
    logic [31:0] rdata;
    word_t       ext_in_word;
    wire flags_t pins;
    logic        busy;
    logic        was_busy;
    note_t       note;
    note_t       rd_q[$];
    flags_t      fl_q[$];
    flags_t      last;
    logic [31:0] seed;
    int          num_errors;
    int          compares;
    int          freeze;

    unsigned_compare_flag_unit i_unsigned_compare_flag_unit (
        .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .ext_in_word(ext_in_word), .greater_flag(pins[0]), .greater_equal_flag(pins[1]),
        .equal_flag(pins[2]), .less_equal_flag(pins[3]), .less_flag(pins[4]),
        .not_equal_flag(pins[5]), .fault_flag(pins[6]), .negative_flag(pins[7]),
        .busy(busy));
    ahb_seq_model i_ahb_seq_model (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .rvalid(rvalid), .rdata(rdata));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // The fault and negative bits are expected to survive every compare.
    function automatic flags_t rel(input logic [31:0] a, input logic [31:0] b);
        flags_t f;
        f = {last[7:6], 6'h00};
        if (a > b) f[5:0] = 6'h23;
        else if (a == b) f[5:0] = 6'h0e;
        else f[5:0] = 6'h38;
        return f;
    endfunction
    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_flags(input flags_t e, input flags_t g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR flag pins expected %h seen %h", e, g);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_ahb_seq_model.xfer(1'b1, a, d);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back('{n, e});
        i_ahb_seq_model.xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic mem(input logic [3:0] i, input word_t w);
        wr(8'h40 + {2'h0, i, 2'h0}, {16'h0000, w});
    endtask
    // Flags are read back before the next compare may overwrite them.
    task automatic run(input logic [31:0] c, input logic [3:0] i1, input logic [3:0] i2,
                       input flags_t e);
        int n;
        wr(`UCF_OFF_OPA, {28'h0000_000, i1});
        wr(`UCF_OFF_OPB, {28'h0000_000, i2});
        fl_q.push_back(e);
        wr(`UCF_OFF_CTRL, c);
        // The bus is idle here, so freezing the block cannot lose a transfer.
        if (freeze > 0) begin
            hce <= 1'b0;
            repeat (freeze) @(posedge hclk);
            hce <= 1'b1;
        end
        rd("status", `UCF_OFF_STATUS, 32'h0000_0001);
        n = 0;
        @(negedge hclk);
        while (busy !== 1'b0 && n < 20) begin
            @(negedge hclk);
            n++;
        end
        if (n >= 20) num_errors++;
        last = e;
        rd("flags", `UCF_OFF_FLAGS, {24'h00_0000, e});
    endtask

    always @(negedge hclk) begin
        if (rvalid === 1'b1) begin
            note = rd_q.pop_front();
            check_word(note.name, note.val, rdata);
            check_word("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
        end
        if (was_busy === 1'b1 && busy === 1'b0) check_flags(fl_q.pop_front(), pins);
        was_busy = busy;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] a;
        logic [31:0] b;
        seed = 32'd24623;
        num_errors = 0;
        compares = 0;
        last = 8'h00;
        was_busy = 1'b0;
        hce = 1'b1;
        hresetn = 1'b0;
        ext_in_word = 16'h0000;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        check_flags(8'h00, pins);
        rd("flags", `UCF_OFF_FLAGS, 32'h0000_0000);
        rd("status", `UCF_OFF_STATUS, 32'h0000_0000);
        $display("test reset done");
        for (int k = 0; k < 12; k++) begin
            a = rnd();
            b = (k % 3 == 0) ? a : rnd();
            if (k == 1) a = 32'h0000_ffff;
            if (k == 1) b = 32'h0000_0000;
            if (k == 2) a = 32'h0000_0000;
            if (k == 2) b = 32'h0000_ffff;
            mem(4'(k + 1), a[15:0]);
            mem(4'(k + 8), b[15:0]);
            run(32'h14, 4'(k + 1), 4'(k + 8), rel({16'h0, a[15:0]}, {16'h0, b[15:0]}));
        end
        $display("test word compare done");
        for (int k = 0; k < 6; k++) begin
            a = rnd();
            b = rnd();
            if (k % 2 == 0) b[31:16] = a[31:16];
            if (k % 3 == 0) b = a;
            if (k == 1) a = 32'hffff_0000;
            if (k == 1) b = 32'hfffe_ffff;
            freeze = (k == 3) ? 3 : 0;
            mem(4'hf, a[15:0]);
            mem(4'h0, a[31:16]);
            mem(4'h6, b[15:0]);
            mem(4'h7, b[31:16]);
            run(32'h3c, 4'hf, 4'h6, rel(a, b));
        end
        freeze = 0;
        $display("test double word compare done");
        last = 8'hff;
        wr(`UCF_OFF_FLAGS, 32'h0000_00ff);
        rd("flags", `UCF_OFF_FLAGS, 32'h0000_00ff);
        mem(4'h2, 16'h0001);
        mem(4'h3, 16'h0002);
        run(32'h14, 4'h2, 4'h3, rel(32'h1, 32'h2));
        last = 8'h40;
        wr(`UCF_OFF_FLAGS, 32'h0000_0040);
        run(32'h3c, 4'h2, 4'h2, rel(32'h0, 32'h0));
        $display("test fault and negative kept done");
        for (int k = 0; k < 2; k++) begin
            a = rnd() | 32'h0000_8000;
            b = (a & 32'h0000_7fff) | 32'h0000_0001;
            ext_in_word <= a[15:0];
            mem(4'h0, 16'h0000);
            mem(4'h3, b[15:0]);
            if (k == 0) run(32'h114, 4'h0, 4'h3, rel({16'h0, a[15:0]}, b));
            else run(32'h114, 4'h3, 4'h0, rel(b, {16'h0, a[15:0]}));
            rd("input word", 8'h40, {16'h0000, a[15:0]});
        end
        $display("test refresh compare done");
        wr(`UCF_OFF_CTRL, 32'h0000_0015);
        repeat (4) @(posedge hclk);
        rd("flags", `UCF_OFF_FLAGS, {24'h00_0000, last});
        rd("unmapped", 8'h20, 32'h0000_0000);
        wr(8'h24, 32'hffff_ffff);
        rd("unmapped", 8'h24, 32'h0000_0000);
        $display("test refused requests done");
        give_verdict();
    end
endmodule
`default_nettype wire
